//--- kgc_consts.svh
// Functional notes
// - Direction read returns two bytes, 1 marks output port, 0 input port.
// - Two-byte port replies send ports 15..8 first, then 7..0, MSB first.
// - Level read returns pull enable for inputs, driven level for outputs.
// - Queue read sends queued event bytes, popping one per byte, until empty.
// - A zero byte follows the last event; host ends it with not-acknowledge.
// - Event byte bit 7 is press (1) or release (0); bits 6..0 name key.
// - Replay read resends the previous queue read without moving read pointer.
// - Halt timeout command takes one byte setting idle time before halt.
// - Timeout zero disables halt; n from 1 to 255 means n times 4 ms.
// - After reset the idle time before halt is 500 ms.
// - Error read returns one byte: bit6 queue, bit2 keys, bit1 command, bit0 parameter.
// - Event arriving while the queue is full sets the queue overrun flag.
// - More than two keys held together sets the too-many-keys flag.
// - Invalid command byte sets unknown flag; invalid parameter sets bad-parameter flag.
// - Settle delay command takes one byte, n times 4 ms, n from 1 to 255.
// - After reset the settle delay is 12 ms.
// - Matrix size byte: columns in bits 7..4, rows in bits 3..0.
// - Column and row pins outside the matrix size are free for port use.
// - Size read returns one byte, columns upper nibble, rows lower nibble.
// - Any set error bit raises the error flag and requests service.
`ifndef KGC_CONSTS_SVH
`define KGC_CONSTS_SVH
`define KGC_CMD_PORT_DIR 8'h87
`define KGC_CMD_PORT_LEVEL 8'h88
`define KGC_CMD_READ_QUEUE 8'h89
`define KGC_CMD_REPLAY_QUEUE 8'h8A
`define KGC_CMD_HALT_TIMEOUT 8'h8B
`define KGC_CMD_ERR_CAUSE 8'h8C
`define KGC_CMD_SETTLE_DELAY 8'h8F
`define KGC_CMD_SET_SIZE 8'h90
`define KGC_CMD_READ_SIZE 8'h91
`define KGC_ERR_QUEUE_BIT 6
`define KGC_ERR_KEYS_BIT 2
`define KGC_ERR_CMD_BIT 1
`define KGC_ERR_PAR_BIT 0
`define KGC_EVT_PRESS_BIT 7
`define KGC_QUEUE_DEPTH 4'hF
`define KGC_MAX_HELD_KEYS 4'h2
`define KGC_TICK_MS 4
`define KGC_CLK_KHZ 200000
`define KGC_TICK_CYCLES (`KGC_TICK_MS * `KGC_CLK_KHZ)
`define KGC_HALT_DEF_MS 500
`define KGC_SETTLE_DEF_MS 12
`define KGC_HALT_RESET 8'(`KGC_HALT_DEF_MS / `KGC_TICK_MS)
`define KGC_SETTLE_RESET 8'(`KGC_SETTLE_DEF_MS / `KGC_TICK_MS)
`define KGC_COLS_MIN 4'h3
`define KGC_COLS_MAX 4'h8
`define KGC_ROWS_MIN 4'h3
`define KGC_ROWS_MAX 4'hC
`define KGC_COLS_RESET 4'h8
`define KGC_ROWS_RESET 4'hC
`define KGC_NUM_COLS 8
`define KGC_NUM_ROWS 12
// Bus address value is arbitrary
`define KGC_DEV_ADDR 7'h2A
`endif

//--- kgc_pkg.sv
`default_nettype none
package kgc_pkg;
  typedef logic [7:0] kgc_byte_t;
  typedef logic [15:0] kgc_port_t;
  typedef logic [3:0] kgc_ptr_t;
  typedef enum logic [2:0] {
    LS_IDLE, LS_ADDR, LS_ADDR_ACK, LS_WRX, LS_WRX_ACK, LS_RD, LS_RD_ACK
  } kgc_link_state_e;
endpackage : kgc_pkg
`default_nettype wire

//--- kgc_link.sv
`timescale 1ns/1ps
`default_nettype none
`include "kgc_consts.svh"
module kgc_link #(
  parameter logic [6:0] DEV_ADDR = `KGC_DEV_ADDR
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire kgc_pkg::kgc_byte_t tx_data_i,
  output kgc_pkg::kgc_byte_t rx_data_o,
  output logic rx_valid_o,
  output logic rx_first_o,
  output logic tx_load_o,
  output logic active_o
);
  import kgc_pkg::*;
  logic scl_s1_r, scl_s2_r, scl_q_r, sda_s1_r, sda_s2_r, sda_q_r;
  kgc_link_state_e st_r;
  logic [3:0] cnt_r;
  kgc_byte_t sh_r;
  logic rw_r, ack_r, drive_r, first_r;
  // Two flops per pin, third flop only for edge finding
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      {scl_s1_r, scl_s2_r, scl_q_r} <= 3'h7;
      {sda_s1_r, sda_s2_r, sda_q_r} <= 3'h7;
    end else begin
      {scl_s1_r, scl_s2_r, scl_q_r} <= {scl_i, scl_s1_r, scl_s2_r};
      {sda_s1_r, sda_s2_r, sda_q_r} <= {sda_i, sda_s1_r, sda_s2_r};
    end
  end
  wire scl_rise = scl_s2_r & ~scl_q_r;
  wire scl_fall = ~scl_s2_r & scl_q_r;
  wire start_c = scl_s2_r & scl_q_r & sda_q_r & ~sda_s2_r;
  wire stop_c = scl_s2_r & scl_q_r & ~sda_q_r & sda_s2_r;
  wire addr_hit = (sh_r[7:1] == DEV_ADDR);
  wire byte_done = (cnt_r == 4'h8);
  // Next byte is fetched on the fall that opens its first bit
  assign tx_load_o = scl_fall & ~start_c & ~stop_c &
    (((st_r == LS_ADDR_ACK) & rw_r) | ((st_r == LS_RD_ACK) & ack_r));
  assign active_o = (st_r != LS_IDLE);
  assign sda_o = 1'b0;
  assign sda_oe_o = drive_r;
  assign rx_first_o = first_r;
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st_r <= LS_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      rw_r <= 1'b0;
      ack_r <= 1'b0;
      drive_r <= 1'b0;
      first_r <= 1'b0;
      rx_data_o <= 8'h00;
      rx_valid_o <= 1'b0;
    end else begin
      rx_valid_o <= 1'b0;
      if (start_c) begin
        st_r <= LS_ADDR;
        cnt_r <= 4'h0;
        drive_r <= 1'b0;
      end else if (stop_c) begin
        st_r <= LS_IDLE;
        drive_r <= 1'b0;
      end else if (scl_rise) begin
        if (st_r == LS_ADDR || st_r == LS_WRX) begin
          sh_r <= {sh_r[6:0], sda_s2_r};
          cnt_r <= cnt_r + 4'h1;
        end
        if (st_r == LS_RD_ACK) begin
          ack_r <= ~sda_s2_r;
        end
      end else if (scl_fall) begin
        unique case (st_r)
          LS_IDLE: begin
          end
          LS_ADDR: if (byte_done) begin
            st_r <= addr_hit ? LS_ADDR_ACK : LS_IDLE;
            drive_r <= addr_hit;
            rw_r <= sh_r[0];
            first_r <= 1'b1;
          end
          LS_WRX: if (byte_done) begin
            st_r <= LS_WRX_ACK;
            drive_r <= 1'b1;
            rx_data_o <= sh_r;
            rx_valid_o <= 1'b1;
          end
          LS_WRX_ACK: begin
            st_r <= LS_WRX;
            drive_r <= 1'b0;
            cnt_r <= 4'h0;
            first_r <= 1'b0;
          end
          LS_ADDR_ACK, LS_RD_ACK: begin
            if (tx_load_o) begin
              st_r <= LS_RD;
              sh_r <= tx_data_i;
              drive_r <= ~tx_data_i[7];
              cnt_r <= 4'h1;
            end else begin
              st_r <= (st_r == LS_ADDR_ACK) ? LS_WRX : LS_IDLE;
              drive_r <= 1'b0;
              cnt_r <= 4'h0;
            end
          end
          LS_RD: begin
            if (byte_done) begin
              st_r <= LS_RD_ACK;
              drive_r <= 1'b0;
            end else begin
              sh_r <= {sh_r[6:0], 1'b0};
              drive_r <= ~sh_r[6];
              cnt_r <= cnt_r + 4'h1;
            end
          end
        endcase
      end
    end
  end
endmodule : kgc_link
`default_nettype wire

//--- kgc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "kgc_consts.svh"
module kgc_top #(
  parameter int TICK_CYCLES = `KGC_TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic key_event_valid_i,
  input wire kgc_pkg::kgc_byte_t key_event_byte_i,
  input wire logic [3:0] keys_held_i,
  input wire kgc_pkg::kgc_port_t port_direction_i,
  input wire kgc_pkg::kgc_port_t port_level_i,
  output kgc_pkg::kgc_byte_t settle_delay_o,
  output kgc_pkg::kgc_byte_t halt_timeout_o,
  output logic [3:0] column_count_o,
  output logic [3:0] row_count_o,
  output logic [`KGC_NUM_COLS-1:0] column_free_o,
  output logic [`KGC_NUM_ROWS-1:0] row_free_o,
  output logic halt_o,
  output logic error_flag_o
);
  import kgc_pkg::*;
  kgc_byte_t rx_data, tx_data, cmd_r, halt_timeout_r, settle_delay_r, error_cause_r;
  logic rx_valid, rx_first, tx_load, link_active;
  logic [3:0] column_count_r, row_count_r;
  logic byte_idx_r, param_seen_r;
  kgc_byte_t queue_mem [16];
  kgc_ptr_t wr_ptr_r, rd_ptr_r, base_ptr_r, replay_ptr_r;
  logic [19:0] tick_cnt_r;
  kgc_byte_t idle_ticks_r;
  logic halt_r;

  kgc_link u_kgc_link (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .tx_data_i(tx_data),
    .rx_data_o(rx_data),
    .rx_valid_o(rx_valid),
    .rx_first_o(rx_first),
    .tx_load_o(tx_load),
    .active_o(link_active)
  );

  // Command decode
  wire cmd_rx = rx_valid & rx_first;
  wire param_rx = rx_valid & ~rx_first & ~param_seen_r;
  wire cmd_known = (rx_data == `KGC_CMD_PORT_DIR) || (rx_data == `KGC_CMD_PORT_LEVEL) ||
    (rx_data == `KGC_CMD_READ_QUEUE) || (rx_data == `KGC_CMD_REPLAY_QUEUE) ||
    (rx_data == `KGC_CMD_HALT_TIMEOUT) || (rx_data == `KGC_CMD_ERR_CAUSE) ||
    (rx_data == `KGC_CMD_SETTLE_DELAY) || (rx_data == `KGC_CMD_SET_SIZE) ||
    (rx_data == `KGC_CMD_READ_SIZE);
  wire set_halt = param_rx & (cmd_r == `KGC_CMD_HALT_TIMEOUT);
  wire set_settle = param_rx & (cmd_r == `KGC_CMD_SETTLE_DELAY);
  wire set_size = param_rx & (cmd_r == `KGC_CMD_SET_SIZE);
  wire settle_ok = (rx_data != 8'h00);
  wire size_ok = (rx_data[7:4] >= `KGC_COLS_MIN) && (rx_data[7:4] <= `KGC_COLS_MAX) &&
    (rx_data[3:0] >= `KGC_ROWS_MIN) && (rx_data[3:0] <= `KGC_ROWS_MAX);
  wire bad_param = (set_settle & ~settle_ok) | (set_size & ~size_ok);

  // Event queue; replay window protected until the next queue read
  wire queue_empty = (rd_ptr_r == wr_ptr_r);
  wire queue_full = (kgc_ptr_t'(wr_ptr_r - base_ptr_r) == `KGC_QUEUE_DEPTH);
  wire push = key_event_valid_i & ~queue_full;
  wire rd_cmd = (cmd_r == `KGC_CMD_READ_QUEUE);
  wire replay_cmd = (cmd_r == `KGC_CMD_REPLAY_QUEUE);
  wire pop = tx_load & rd_cmd & ~queue_empty;
  wire replay_more = (replay_ptr_r != rd_ptr_r);
  wire replay_step = tx_load & replay_cmd & replay_more;

  // Reply byte selection
  wire kgc_byte_t port_dir_byte = byte_idx_r ? port_direction_i[7:0] : port_direction_i[15:8];
  wire kgc_byte_t port_lvl_byte = byte_idx_r ? port_level_i[7:0] : port_level_i[15:8];
  wire kgc_byte_t queue_byte = queue_empty ? 8'h00 : queue_mem[rd_ptr_r];
  wire kgc_byte_t replay_byte = replay_more ? queue_mem[replay_ptr_r] : 8'h00;
  wire kgc_byte_t size_byte = {column_count_r, row_count_r};
  assign tx_data =
    (cmd_r == `KGC_CMD_PORT_DIR) ? port_dir_byte :
    (cmd_r == `KGC_CMD_PORT_LEVEL) ? port_lvl_byte :
    rd_cmd ? queue_byte :
    replay_cmd ? replay_byte :
    (cmd_r == `KGC_CMD_ERR_CAUSE) ? error_cause_r :
    (cmd_r == `KGC_CMD_READ_SIZE) ? size_byte : 8'h00;

  // Command latch and reply sequencing
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cmd_r <= 8'h00;
      byte_idx_r <= 1'b0;
      param_seen_r <= 1'b0;
    end else if (cmd_rx) begin
      cmd_r <= rx_data;
      byte_idx_r <= 1'b0;
      param_seen_r <= 1'b0;
    end else begin
      if (tx_load) begin
        byte_idx_r <= 1'b1;
      end
      if (param_rx) begin
        param_seen_r <= 1'b1;
      end
    end
  end

  // Settings; invalid parameters leave the old value
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      halt_timeout_r <= `KGC_HALT_RESET;
      settle_delay_r <= `KGC_SETTLE_RESET;
      column_count_r <= `KGC_COLS_RESET;
      row_count_r <= `KGC_ROWS_RESET;
    end else begin
      if (set_halt) begin
        halt_timeout_r <= rx_data;
      end
      if (set_settle & settle_ok) begin
        settle_delay_r <= rx_data;
      end
      if (set_size & size_ok) begin
        column_count_r <= rx_data[7:4];
        row_count_r <= rx_data[3:0];
      end
    end
  end
  assign halt_timeout_o = halt_timeout_r;
  assign settle_delay_o = settle_delay_r;
  assign column_count_o = column_count_r;
  assign row_count_o = row_count_r;

  for (genvar i = 0; i < `KGC_NUM_ROWS; i++) begin : g_free
    if (i < `KGC_NUM_COLS) begin : g_col
      assign column_free_o[i] = (4'(i) >= column_count_r);
    end
    assign row_free_o[i] = (4'(i) >= row_count_r);
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      queue_mem[wr_ptr_r] <= key_event_byte_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wr_ptr_r <= 4'h0;
      rd_ptr_r <= 4'h0;
      base_ptr_r <= 4'h0;
      replay_ptr_r <= 4'h0;
    end else begin
      wr_ptr_r <= wr_ptr_r + 4'(push);
      rd_ptr_r <= rd_ptr_r + 4'(pop);
      if (cmd_rx && rx_data == `KGC_CMD_READ_QUEUE) begin
        base_ptr_r <= rd_ptr_r;
      end
      if (cmd_rx && rx_data == `KGC_CMD_REPLAY_QUEUE) begin
        replay_ptr_r <= base_ptr_r;
      end else begin
        replay_ptr_r <= replay_ptr_r + 4'(replay_step);
      end
    end
  end

  // Error cause; a new event wins over the read clear
  wire err_read = tx_load & (cmd_r == `KGC_CMD_ERR_CAUSE);
  kgc_byte_t err_set;
  always_comb begin
    err_set = 8'h00;
    err_set[`KGC_ERR_QUEUE_BIT] = key_event_valid_i & queue_full;
    err_set[`KGC_ERR_KEYS_BIT] = (keys_held_i > `KGC_MAX_HELD_KEYS);
    err_set[`KGC_ERR_CMD_BIT] = cmd_rx & ~cmd_known;
    err_set[`KGC_ERR_PAR_BIT] = bad_param;
  end
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      error_cause_r <= 8'h00;
    end else begin
      error_cause_r <= (err_read ? 8'h00 : error_cause_r) | err_set;
    end
  end
  assign error_flag_o = |error_cause_r;

  // Idle timer in 4 ms ticks; any key or bus activity restarts it
  wire activity = key_event_valid_i | link_active;
  wire tick = (tick_cnt_r == 20'(TICK_CYCLES - 1));
  always_ff @(posedge clk_i) begin
    if (!resetn_i || activity || tick) begin
      tick_cnt_r <= 20'h0_0000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 20'h0_0001;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!resetn_i || activity) begin
      idle_ticks_r <= 8'h00;
      halt_r <= 1'b0;
    end else begin
      if (tick && idle_ticks_r != 8'hFF) begin
        idle_ticks_r <= idle_ticks_r + 8'h01;
      end
      halt_r <= (halt_timeout_r != 8'h00) && (idle_ticks_r >= halt_timeout_r);
    end
  end
  assign halt_o = halt_r;

  property p_queue_ovr;
    @(posedge clk_i) disable iff (!resetn_i)
    key_event_valid_i && queue_full |=> error_cause_r[`KGC_ERR_QUEUE_BIT];
  endproperty
  a_queue_ovr: assert property (p_queue_ovr) else $error("queue overrun not flagged");
  property p_keys_ovr;
    @(posedge clk_i) disable iff (!resetn_i)
    keys_held_i > `KGC_MAX_HELD_KEYS |=> error_cause_r[`KGC_ERR_KEYS_BIT];
  endproperty
  a_keys_ovr: assert property (p_keys_ovr) else $error("key overrun not flagged");
  property p_unknown;
    @(posedge clk_i) disable iff (!resetn_i)
    cmd_rx && !cmd_known |=> error_cause_r[`KGC_ERR_CMD_BIT] && error_flag_o;
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown command not flagged");
  property p_err_flag;
    @(posedge clk_i) disable iff (!resetn_i)
    err_set != 8'h00 |=> error_flag_o;
  endproperty
  a_err_flag: assert property (p_err_flag) else $error("error flag mismatch");
  property p_pop;
    @(posedge clk_i) disable iff (!resetn_i)
    tx_load && rd_cmd && !queue_empty |=> rd_ptr_r == 4'($past(rd_ptr_r) + 4'h1);
  endproperty
  a_pop: assert property (p_pop) else $error("queue read did not pop");
  property p_replay_hold;
    @(posedge clk_i) disable iff (!resetn_i)
    replay_cmd |=> $stable(rd_ptr_r);
  endproperty
  a_replay_hold: assert property (p_replay_hold) else $error("replay moved read pointer");
  property p_zero_end;
    @(posedge clk_i) disable iff (!resetn_i)
    rd_cmd && queue_empty |-> tx_data == 8'h00;
  endproperty
  a_zero_end: assert property (p_zero_end) else $error("missing zero end byte");
  property p_size_read;
    @(posedge clk_i) disable iff (!resetn_i)
    cmd_r == `KGC_CMD_READ_SIZE |-> tx_data == {column_count_o, row_count_o};
  endproperty
  a_size_read: assert property (p_size_read) else $error("size reply wrong");
  property p_dir_order;
    @(posedge clk_i) disable iff (!resetn_i)
    cmd_rx && rx_data == `KGC_CMD_PORT_DIR |=> tx_data == port_direction_i[15:8];
  endproperty
  a_dir_order: assert property (p_dir_order) else $error("direction high byte not first");
  property p_no_halt;
    @(posedge clk_i) disable iff (!resetn_i)
    halt_timeout_r == 8'h00 |=> !halt_o;
  endproperty
  a_no_halt: assert property (p_no_halt) else $error("halt with timeout zero");
  property p_err_clear;
    @(posedge clk_i) disable iff (!resetn_i)
    err_read && err_set == 8'h00 |=> error_cause_r == 8'h00;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error bits not cleared");
endmodule : kgc_top
`default_nettype wire

//--- kgc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module kgc_host_model (
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  // Link clock stands high between frames; data line released
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // Waits out the device's ack hold before raising data
  task automatic start_cond();
    #16 sda_o = 1'b1;
    #16 scl_o = 1'b1;
    #32 sda_o = 1'b0;
    #32 scl_o = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    #16 sda_o = 1'b0;
    #16 scl_o = 1'b1;
    #32 sda_o = 1'b1;
    #32;
  endtask : stop_cond

  // Samples late in the high phase, after the device's answer settles
  task automatic put_bit(input logic b, output logic got);
    #16 sda_o = b;
    #16 scl_o = 1'b1;
    #28 got = sda_i;
    #4 scl_o = 1'b0;
  endtask : put_bit

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic unused;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], unused);
    end
    put_bit(1'b1, ack);
  endtask : wr_byte

  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic unused;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, d[i]);
    end
    put_bit(last, unused);
  endtask : rd_byte
endmodule : kgc_host_model
`default_nettype wire

//--- kgc_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "kgc_consts.svh"
`define KGC_CHECK(g, e, m) \
  begin \
    tests_run++; \
    if ((g) !== (e)) begin \
      error_cnt++; \
      $display("CHECK FAILED t=%0t %s got %0h exp %0h", $time, m, g, e); \
    end \
  end
module kgc_top_bench;
  import kgc_pkg::*;
  typedef struct {
    kgc_byte_t cmd;
    kgc_byte_t par;
    kgc_byte_t settle;
    kgc_byte_t halt;
    logic [3:0] cols;
    logic [3:0] rows;
  } kgc_row_s;
  int error_cnt = 0;
  int tests_run = 0;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic scl;
  logic host_sda;
  logic sda_line;
  logic sda_o;
  logic sda_oe_o;
  logic key_event_valid_i = 1'b0;
  kgc_byte_t key_event_byte_i = 8'h00;
  logic [3:0] keys_held_i = 4'h0;
  kgc_port_t port_direction_i = 16'h0000;
  kgc_port_t port_level_i = 16'h0000;
  kgc_byte_t settle_delay_o;
  kgc_byte_t halt_timeout_o;
  logic [3:0] column_count_o;
  logic [3:0] row_count_o;
  logic [7:0] column_free_o;
  logic [11:0] row_free_o;
  logic halt_o;
  logic error_flag_o;
  kgc_byte_t exp_q[$];
  // Legal rows keep settle below timeout; rows 3 and 4 probe refused values
  // host duties kept by these rows
  kgc_row_s rows[6] = '{
    '{8'h8F, 8'h05, 8'h05, 8'h7D, 4'h8, 4'hC},
    '{8'h8B, 8'h10, 8'h05, 8'h10, 4'h8, 4'hC},
    '{8'h90, 8'h35, 8'h05, 8'h10, 4'h3, 4'h5},
    '{8'h90, 8'h2C, 8'h05, 8'h10, 4'h3, 4'h5},
    '{8'h8F, 8'h00, 8'h05, 8'h10, 4'h3, 4'h5},
    '{8'h90, 8'h8C, 8'h05, 8'h10, 4'h8, 4'hC}
  };

  always #2.5 clk_i = ~clk_i;
  // Open-drain line with pull-up
  assign sda_line = sda_oe_o ? (sda_o & host_sda) : host_sda;

  kgc_host_model u_kgc_host_model (
    .sda_i(sda_line),
    .scl_o(scl),
    .sda_o(host_sda)
  );

  kgc_top #(.TICK_CYCLES(20)) u_kgc_top (
    .clk_i(clk_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .key_event_valid_i(key_event_valid_i),
    .key_event_byte_i(key_event_byte_i), .keys_held_i(keys_held_i),
    .port_direction_i(port_direction_i), .port_level_i(port_level_i),
    .settle_delay_o(settle_delay_o), .halt_timeout_o(halt_timeout_o),
    .column_count_o(column_count_o), .row_count_o(row_count_o),
    .column_free_o(column_free_o), .row_free_o(row_free_o),
    .halt_o(halt_o), .error_flag_o(error_flag_o)
  );

  task automatic end_test(input string name);
    $display("test done: %s", name);
  endtask : end_test

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  task automatic send_cmd(input kgc_byte_t cmd);
    logic ack;
    @(negedge clk_i);
    u_kgc_host_model.start_cond();
    u_kgc_host_model.wr_byte({`KGC_DEV_ADDR, 1'b0}, ack);
    `KGC_CHECK(ack, 1'b0, "address ack")
    u_kgc_host_model.wr_byte(cmd, ack);
    `KGC_CHECK(ack, 1'b0, "command ack")
  endtask : send_cmd

  task automatic wr_cmd(input kgc_byte_t cmd, input kgc_byte_t par);
    logic ack;
    send_cmd(cmd);
    u_kgc_host_model.wr_byte(par, ack);
    `KGC_CHECK(ack, 1'b0, "parameter ack")
    u_kgc_host_model.stop_cond();
    repeat (4) @(negedge clk_i);
  endtask : wr_cmd

  // Reads as many bytes as expected, refusing the last one
  task automatic expect_reply(input kgc_byte_t cmd, input kgc_byte_t exp[$]);
    logic ack;
    kgc_byte_t got;
    send_cmd(cmd);
    u_kgc_host_model.start_cond();
    u_kgc_host_model.wr_byte({`KGC_DEV_ADDR, 1'b1}, ack);
    `KGC_CHECK(ack, 1'b0, "read address ack")
    foreach (exp[i]) begin
      u_kgc_host_model.rd_byte(i == exp.size() - 1, got);
      `KGC_CHECK(got, exp[i], "reply byte")
    end
    u_kgc_host_model.stop_cond();
    repeat (4) @(negedge clk_i);
  endtask : expect_reply

  task automatic push_key(input kgc_byte_t b);
    @(negedge clk_i);
    key_event_valid_i = 1'b1;
    key_event_byte_i = b;
    @(negedge clk_i);
    key_event_valid_i = 1'b0;
  endtask : push_key

  initial begin
    repeat (80000) @(posedge clk_i);
    error_cnt++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    close_out();
  end

  initial begin
    repeat (12) @(negedge clk_i);
    resetn_i = 1'b1;
    @(negedge clk_i);
    `KGC_CHECK(settle_delay_o, 8'h03, "settle default")
    `KGC_CHECK(halt_timeout_o, 8'h7D, "timeout default")
    `KGC_CHECK({column_count_o, row_count_o}, 8'h8C, "size default")
    `KGC_CHECK(error_flag_o, 1'b0, "no error")
    repeat (2470) @(negedge clk_i);
    `KGC_CHECK(halt_o, 1'b0, "awake before default")
    repeat (40) @(negedge clk_i);
    `KGC_CHECK(halt_o, 1'b1, "halt at default")
    end_test("reset");
    foreach (rows[i]) begin
      wr_cmd(rows[i].cmd, rows[i].par);
      `KGC_CHECK(settle_delay_o, rows[i].settle, "settle")
      `KGC_CHECK(halt_timeout_o, rows[i].halt, "timeout")
      `KGC_CHECK({column_count_o, row_count_o}, {rows[i].cols, rows[i].rows}, "size")
    end
    end_test("settings table");
    send_cmd(8'h8D);
    u_kgc_host_model.stop_cond();
    repeat (4) @(negedge clk_i);
    `KGC_CHECK(error_flag_o, 1'b1, "error flag")
    expect_reply(8'h8C, '{8'h03});
    expect_reply(8'h8C, '{8'h00});
    `KGC_CHECK(error_flag_o, 1'b0, "error flag cleared")
    @(negedge clk_i);
    keys_held_i = 4'h3;
    repeat (3) @(negedge clk_i);
    keys_held_i = 4'h2;
    repeat (3) @(negedge clk_i);
    expect_reply(8'h8C, '{8'h04});
    end_test("errors");
    port_direction_i = 16'hA53C;
    port_level_i = 16'h5AC3;
    expect_reply(8'h87, '{8'hA5, 8'h3C});
    expect_reply(8'h88, '{8'h5A, 8'hC3});
    wr_cmd(8'h90, 8'h46);
    `KGC_CHECK(column_free_o, 8'hF0, "free columns")
    `KGC_CHECK(row_free_o, 12'hFC0, "free rows")
    expect_reply(8'h91, '{8'h46});
    end_test("ports and size");
    push_key(8'h81);
    push_key(8'h05);
    push_key(8'hC2);
    expect_reply(8'h89, '{8'h81, 8'h05, 8'hC2, 8'h00});
    expect_reply(8'h8A, '{8'h81, 8'h05, 8'hC2, 8'h00});
    expect_reply(8'h89, '{8'h00});
    for (int i = 0; i < 16; i++) begin
      push_key(8'h80 | 8'(i));
      if (i < 15) begin
        exp_q.push_back(8'h80 | 8'(i));
      end
    end
    exp_q.push_back(8'h00);
    @(negedge clk_i);
    `KGC_CHECK(error_flag_o, 1'b1, "overrun flag")
    expect_reply(8'h8C, '{8'h40});
    expect_reply(8'h89, exp_q);
    end_test("event queue");
    wr_cmd(8'h8B, 8'h05);
    repeat (80) @(negedge clk_i);
    `KGC_CHECK(halt_o, 1'b0, "awake before timeout")
    repeat (40) @(negedge clk_i);
    `KGC_CHECK(halt_o, 1'b1, "halt after timeout")
    wr_cmd(8'h8B, 8'h00);
    repeat (300) @(negedge clk_i);
    `KGC_CHECK(halt_o, 1'b0, "halt disabled")
    end_test("halt");
    close_out();
  end
endmodule : kgc_top_bench
`default_nettype wire
